/* logic/fcd_accum.sv */
// Accumulator bank with its move-in formats
`default_nettype none

module fcd_accum
#(
  parameter int NUM_ACC = 4,
  parameter int SEL_W   = 2
)
(
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic                     wr_en,
  input  wire logic [SEL_W-1:0]         wr_sel,
  input  wire fcd_pkg::fcd_op_t         wr_kind,
  input  wire logic [fcd_pkg::XLEN-1:0] wr_src,
  input  wire logic [SEL_W-1:0]         rd_sel,
  output logic [fcd_pkg::ACC_W-1:0]     rd_data
);

  logic [fcd_pkg::ACC_W-1:0] acc_r [NUM_ACC];

  assign rd_data = acc_r[rd_sel];

  // ----------------------------------------------------------------
  // One writer per accumulator
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_ACC; g++)
  begin : g_acc
    always_ff @(posedge clk)
    begin
      if (rst)
        acc_r[g] <= fcd_pkg::ACC_RST;
      else if (ce && wr_en && wr_sel == SEL_W'(g))
      begin
        if (wr_kind == fcd_pkg::OP_ACC_LO)
          acc_r[g][31:0] <= wr_src[31:0];
        else if (wr_kind == fcd_pkg::OP_ACC_MID)
          acc_r[g][63:32] <= wr_src[31:0];
        else if (wr_kind == fcd_pkg::OP_ACC_TOP8)
          acc_r[g][71:64] <= wr_src[7:0];
        else if (wr_kind == fcd_pkg::OP_ACC_SX32)
          acc_r[g] <= {{40{wr_src[31]}}, wr_src[31:0]};
        else if (wr_kind == fcd_pkg::OP_ACC_SX64)
          acc_r[g] <= {{8{wr_src[63]}}, wr_src};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  acc_low_keep_a: assert property (
    ce && wr_en && wr_kind == fcd_pkg::OP_ACC_LO |=>
      acc_r[$past(wr_sel)][31:0] == $past(wr_src[31:0]) &&
      acc_r[$past(wr_sel)][71:32] == $past(acc_r[wr_sel][71:32]))
    else $error("accumulator low move wrong");

  acc_top8_a: assert property (
    ce && wr_en && wr_kind == fcd_pkg::OP_ACC_TOP8 |=>
      acc_r[$past(wr_sel)][71:64] == $past(wr_src[7:0]) &&
      acc_r[$past(wr_sel)][63:0] == $past(acc_r[wr_sel][63:0]))
    else $error("accumulator top byte move wrong");

  acc_sext_a: assert property (
    ce && wr_en && wr_kind == fcd_pkg::OP_ACC_SX32 |=>
      acc_r[$past(wr_sel)] ==
        {{40{$past(wr_src[31])}}, $past(wr_src[31:0])})
    else $error("accumulator sign extension wrong");

endmodule : fcd_accum

`default_nettype wire

/* logic/fcd_decode.sv */
// Instruction decoder of the coprocessor front end
`default_nettype none

module fcd_decode
(
  input  wire logic [31:0]     instr,
  output fcd_pkg::fcd_op_t     op,
  output logic                 is_int
);

  logic [3:0] cp;
  logic [2:0] op2;
  logic [1:0] op1;
  logic       f_flt;
  logic       f_int;
  logic       f_ext;

  assign cp     = instr[fcd_pkg::F_CP +: 4];
  assign op2    = instr[fcd_pkg::F_OP2 +: 3];
  assign op1    = instr[fcd_pkg::F_DP_OP1 +: 2];
  assign f_flt  = (cp == fcd_pkg::CP_FLOAT);
  assign f_int  = (cp == fcd_pkg::CP_INT);
  assign f_ext  = (cp == fcd_pkg::CP_EXT);
  assign is_int = f_int;

  always_comb
  begin
    op = fcd_pkg::OP_NONE;
    // Load and store, width and direction only
    if (instr[fcd_pkg::F_CLASS_HI -: 3] == fcd_pkg::CLASS_LS)
    begin
      if (f_flt || f_int)
      begin
        unique case ({instr[fcd_pkg::F_LS_WIDE], instr[fcd_pkg::F_LS_LOAD]})
          2'b00: op = f_flt ? fcd_pkg::OP_ST_S : fcd_pkg::OP_ST_32;
          2'b01: op = f_flt ? fcd_pkg::OP_LD_S : fcd_pkg::OP_LD_32;
          2'b10: op = f_flt ? fcd_pkg::OP_ST_D : fcd_pkg::OP_ST_64;
          2'b11: op = f_flt ? fcd_pkg::OP_LD_D : fcd_pkg::OP_LD_64;
        endcase
      end
    end
    else if (instr[fcd_pkg::F_CLASS_HI -: 4] == fcd_pkg::CLASS_CO &&
             !instr[fcd_pkg::F_XFER_BIT])
    begin
      // Data operations
      unique case (op1)
        2'b00:
        begin
          if (f_flt || f_int)
            op = fcd_pkg::OP_DP_OTHER;
        end
        2'b01:
        begin
          if (f_flt || f_int || (f_ext && op2 == 3'h0))
            op = fcd_pkg::OP_DP_OTHER;
        end
        2'b10:
        begin
          if (f_flt)
          begin
            unique case (op2)
              3'h2:    op = fcd_pkg::OP_ACC_LO;
              3'h3:    op = fcd_pkg::OP_ACC_MID;
              3'h4:    op = fcd_pkg::OP_ACC_TOP8;
              3'h5:    op = fcd_pkg::OP_ACC_SX32;
              3'h6:    op = fcd_pkg::OP_ACC_SX64;
              3'h7:    op = fcd_pkg::OP_DP_OTHER;
              default: op = fcd_pkg::OP_NONE;
            endcase
          end
          else if (f_int || f_ext)
            op = fcd_pkg::OP_DP_OTHER;
        end
        2'b11:
        begin
          if (f_flt || f_int)
          begin
            unique case (op2[2:1])
              2'b00: op = fcd_pkg::OP_ABS;
              2'b01: op = fcd_pkg::OP_NEG;
              2'b10: op = fcd_pkg::OP_ADD;
              2'b11: op = fcd_pkg::OP_SUB;
            endcase
          end
          else if (f_ext && (op2 == 3'h3 || op2 == 3'h4))
            op = fcd_pkg::OP_DP_OTHER;
        end
      endcase
    end
    else if (instr[fcd_pkg::F_CLASS_HI -: 4] == fcd_pkg::CLASS_CO &&
             instr[fcd_pkg::F_MX_OP1 +: 3] == 3'h0)
    begin
      if (!instr[fcd_pkg::F_XFER_RD])
      begin
        // Host to coprocessor
        if (f_flt)
        begin
          unique case (op2)
            3'h0:    op = fcd_pkg::OP_MV_DLR;
            3'h1:    op = fcd_pkg::OP_MV_DHR;
            3'h2:    op = fcd_pkg::OP_MV_SR;
            default: op = fcd_pkg::OP_NONE;
          endcase
        end
        else if (f_int)
        begin
          unique case (op2)
            3'h0:    op = fcd_pkg::OP_MV_64LR;
            3'h1:    op = fcd_pkg::OP_MV_64HR;
            3'h2:    op = fcd_pkg::OP_RSHL32;
            3'h3:    op = fcd_pkg::OP_RSHL64;
            default: op = fcd_pkg::OP_NONE;
          endcase
        end
      end
      else if (f_flt || f_int)
      begin
        unique case (op2)
          3'h0:    op = f_flt ? fcd_pkg::OP_MV_RDL : fcd_pkg::OP_MV_R64L;
          3'h1:    op = f_flt ? fcd_pkg::OP_MV_RDH : fcd_pkg::OP_MV_R64H;
          3'h2:    op = f_flt ? fcd_pkg::OP_MV_RS : fcd_pkg::OP_NONE;
          3'h4:    op = fcd_pkg::OP_CMP;
          3'h5:    op = fcd_pkg::OP_CMP;
          default: op = fcd_pkg::OP_NONE;
        endcase
      end
    end
  end

endmodule : fcd_decode

`default_nettype wire

/* logic/fcd_pkg.sv */
// Shared constants and types of the coprocessor decode front end
`default_nettype none

package fcd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int XLEN      = 64;
  localparam int ACC_W     = 72;
  localparam int NUM_CREGS = 16;
  localparam int IDX_W     = 4;
  localparam int IMM_W     = 7;
  localparam int WORD_W    = 32;

  // ----------------------------------------------------------------
  // Instruction field positions
  // ----------------------------------------------------------------
  localparam int F_CLASS_HI = 27;
  localparam int F_LS_WIDE  = 22;
  localparam int F_LS_LOAD  = 20;
  localparam int F_MX_OP1   = 21;
  localparam int F_XFER_RD  = 20;
  localparam int F_DP_OP1   = 20;
  localparam int F_CRN      = 16;
  localparam int F_CRD      = 12;
  localparam int F_CP       = 8;
  localparam int F_OP2      = 5;
  localparam int F_XFER_BIT = 4;
  localparam int F_CRM      = 0;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLASS_LS  = 3'h6;
  localparam logic [3:0] CLASS_CO  = 4'hE;
  localparam logic [3:0] CP_FLOAT  = 4'h4;
  localparam logic [3:0] CP_INT    = 4'h5;
  localparam logic [3:0] CP_EXT    = 4'h6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [XLEN-1:0]  DATA_RST = 64'h0;
  localparam logic [ACC_W-1:0] ACC_RST  = 72'h0;

  typedef enum logic [5:0] {
    OP_NONE,
    OP_LD_S, OP_LD_D, OP_LD_32, OP_LD_64,
    OP_ST_S, OP_ST_D, OP_ST_32, OP_ST_64,
    OP_MV_SR, OP_MV_DLR, OP_MV_DHR, OP_MV_64LR, OP_MV_64HR,
    OP_RSHL32, OP_RSHL64,
    OP_MV_RS, OP_MV_RDL, OP_MV_RDH, OP_MV_R64L, OP_MV_R64H,
    OP_CMP,
    OP_ACC_LO, OP_ACC_MID, OP_ACC_TOP8, OP_ACC_SX32, OP_ACC_SX64,
    OP_ABS, OP_NEG, OP_ADD, OP_SUB,
    OP_DP_OTHER
  } fcd_op_t;

endpackage : fcd_pkg

`default_nettype wire

/* logic/fcd_top.sv */
// Coprocessor decode and data-movement front end, top level
`default_nettype none

// What this block does
// - Load/store bits 22,20: 00 store32, 01 load32, 10 store64, 11 load64.
// - Load/store accepts number 0100 for float, 0101 for integer.
// - Data ops from primary, number, secondary; primary 11 is abs/neg/add/sub for float and integer numbers.
// - Host-to-unit: 000 low, 001 high, 010 single or 010/011 shifts by number.
// - Unit-to-host: 000 low, 001 high, 010 single, 100/101 compares.
// - Sixteen 64-bit registers, any reachable from every register field.
// - Accumulator field selects any accumulator.
// - Immediate operand is seven bits wide.
// - 32-bit integer load sign-extends through bit 63.
// - Loads of single, double and 64-bit integer values.
// - Stores of single, double, 32-bit and 64-bit values.
// - Single move from host fills bits 63:32.
// - Double half moves fill bits 31:0 or 63:32.
// - Integer low-half move sign-extends bit 31 upward; high fills 63:32.
// - Low-half reads return bits 31:0.
// - High-half and single reads return bits 63:32.
// - Accumulator low move writes 31:0 only.
// - Accumulator middle move writes 63:32.
// - Accumulator top move writes low byte into 71:64.
// - 32-bit accumulator move sign-extends through bit 71.
// - 64-bit accumulator move sign-extends through bit 71.
// - Width bit picks 32 or 64; index, direction, writeback, offset ignored.
module fcd_top
#(
  parameter int NUM_ACC = 4
)
(
  input  wire logic                        CLK,
  input  wire logic                        RST,
  input  wire logic                        CE,
  input  wire logic                        INSTR_VALID,
  input  wire logic [31:0]                 INSTR,
  input  wire logic [fcd_pkg::XLEN-1:0]    WDATA,
  output logic                             ACCEPT,
  output logic                             RD_VALID,
  output logic [fcd_pkg::XLEN-1:0]         RD_DATA,
  output logic                             DP_VALID,
  output fcd_pkg::fcd_op_t                 DP_OP,
  output logic                             DP_WIDE,
  output logic                             DP_INT,
  output logic [fcd_pkg::IDX_W-1:0]        DP_DEST,
  output logic [fcd_pkg::IDX_W-1:0]        DP_SRC1,
  output logic [fcd_pkg::IDX_W-1:0]        DP_SRC2,
  output logic [fcd_pkg::IMM_W-1:0]        DP_IMM,
  output logic [fcd_pkg::XLEN-1:0]         DP_SRC1_DATA,
  output logic [fcd_pkg::XLEN-1:0]         DP_SRC2_DATA,
  output logic [fcd_pkg::WORD_W-1:0]       DP_HOST_DATA,
  output logic [fcd_pkg::ACC_W-1:0]        DP_ACC_DATA
);

  localparam int SEL_W = (NUM_ACC > 1) ? $clog2(NUM_ACC) : 1;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (NUM_ACC < 2 || NUM_ACC > fcd_pkg::NUM_CREGS ||
      NUM_ACC != (1 << SEL_W))
  begin : g_bad_acc
    $error("NUM_ACC must be a power of two from 2 to 16");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  fcd_pkg::fcd_op_t           dec_op;
  logic                       dec_int;
  logic                       take;
  logic                       known;
  logic                       is_dp;
  logic                       is_read;
  logic [fcd_pkg::IDX_W-1:0]  dest_creg;
  logic [fcd_pkg::IDX_W-1:0]  first_src_creg;
  logic [fcd_pkg::IDX_W-1:0]  second_src_creg;
  logic [SEL_W-1:0]           accum_select;
  logic [SEL_W-1:0]           accum_read_sel;
  logic [fcd_pkg::IMM_W-1:0]  imm_nxt;
  logic [fcd_pkg::XLEN-1:0]   rd_nxt;
  logic [fcd_pkg::ACC_W-1:0]  acc_rd;
  logic [fcd_pkg::XLEN-1:0]   creg_r [fcd_pkg::NUM_CREGS];

  fcd_decode u_decode
  (
    .instr  (INSTR),
    .op     (dec_op),
    .is_int (dec_int)
  );

  // Condition, base register, index and offset bits are never examined
  assign dest_creg       = INSTR[fcd_pkg::F_CRD +: fcd_pkg::IDX_W];
  assign first_src_creg  = INSTR[fcd_pkg::F_CRN +: fcd_pkg::IDX_W];
  assign second_src_creg = INSTR[fcd_pkg::F_CRM +: fcd_pkg::IDX_W];
  assign accum_select    = SEL_W'(dest_creg);
  assign accum_read_sel  = SEL_W'(first_src_creg);
  assign imm_nxt         = {INSTR[fcd_pkg::F_OP2 +: 3], second_src_creg};

  assign take  = CE && INSTR_VALID;
  assign known = (dec_op != fcd_pkg::OP_NONE);

  always_comb
  begin
    is_dp   = 1'b0;
    is_read = 1'b0;
    unique case (dec_op)
      fcd_pkg::OP_ABS, fcd_pkg::OP_NEG, fcd_pkg::OP_ADD, fcd_pkg::OP_SUB,
      fcd_pkg::OP_DP_OTHER, fcd_pkg::OP_CMP,
      fcd_pkg::OP_RSHL32, fcd_pkg::OP_RSHL64:
        is_dp = 1'b1;
      fcd_pkg::OP_ST_S, fcd_pkg::OP_ST_D, fcd_pkg::OP_ST_32,
      fcd_pkg::OP_ST_64, fcd_pkg::OP_MV_RS, fcd_pkg::OP_MV_RDL,
      fcd_pkg::OP_MV_RDH, fcd_pkg::OP_MV_R64L, fcd_pkg::OP_MV_R64H:
        is_read = 1'b1;
      default:
      begin
        is_dp   = 1'b0;
        is_read = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Data returned to the host or to memory
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_nxt = fcd_pkg::DATA_RST;
    unique case (dec_op)
      fcd_pkg::OP_ST_S:
        rd_nxt = {32'h0, creg_r[dest_creg][63:32]};
      fcd_pkg::OP_ST_32:
        rd_nxt = {32'h0, creg_r[dest_creg][31:0]};
      fcd_pkg::OP_ST_D, fcd_pkg::OP_ST_64:
        rd_nxt = creg_r[dest_creg];
      fcd_pkg::OP_MV_RDL, fcd_pkg::OP_MV_R64L:
        rd_nxt = {32'h0, creg_r[first_src_creg][31:0]};
      fcd_pkg::OP_MV_RS, fcd_pkg::OP_MV_RDH, fcd_pkg::OP_MV_R64H:
        rd_nxt = {32'h0, creg_r[first_src_creg][63:32]};
      default:
        rd_nxt = fcd_pkg::DATA_RST;
    endcase
  end

  // ----------------------------------------------------------------
  // General registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (!RST && take)
    begin
      unique case (dec_op)
        fcd_pkg::OP_LD_S:
          creg_r[dest_creg][63:32] <= WDATA[31:0];
        fcd_pkg::OP_LD_D, fcd_pkg::OP_LD_64:
          creg_r[dest_creg] <= WDATA;
        fcd_pkg::OP_LD_32:
          creg_r[dest_creg] <= {{32{WDATA[31]}}, WDATA[31:0]};
        fcd_pkg::OP_MV_SR, fcd_pkg::OP_MV_DHR, fcd_pkg::OP_MV_64HR:
          creg_r[first_src_creg][63:32] <= WDATA[31:0];
        fcd_pkg::OP_MV_DLR:
          creg_r[first_src_creg][31:0] <= WDATA[31:0];
        fcd_pkg::OP_MV_64LR:
          creg_r[first_src_creg] <=
            {{32{WDATA[31]}}, WDATA[31:0]};
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Accumulators
  // ----------------------------------------------------------------
  fcd_accum
  #(
    .NUM_ACC (NUM_ACC),
    .SEL_W   (SEL_W)
  )
  u_accum
  (
    .clk     (CLK),
    .rst     (RST),
    .ce      (CE),
    .wr_en   (INSTR_VALID),
    .wr_sel  (accum_select),
    .wr_kind (dec_op),
    .wr_src  (creg_r[first_src_creg]),
    .rd_sel  (accum_read_sel),
    .rd_data (acc_rd)
  );

  // ----------------------------------------------------------------
  // Answer strobes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ACCEPT   <= 1'b0;
      RD_VALID <= 1'b0;
      DP_VALID <= 1'b0;
    end
    else if (CE)
    begin
      ACCEPT   <= INSTR_VALID && known;
      RD_VALID <= INSTR_VALID && is_read;
      DP_VALID <= INSTR_VALID && is_dp;
    end
  end

  // ----------------------------------------------------------------
  // Answer data and forwarded operands
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      RD_DATA      <= fcd_pkg::DATA_RST;
      DP_OP        <= fcd_pkg::OP_NONE;
      DP_WIDE      <= 1'b0;
      DP_INT       <= 1'b0;
      DP_DEST      <= '0;
      DP_SRC1      <= '0;
      DP_SRC2      <= '0;
      DP_IMM       <= '0;
      DP_SRC1_DATA <= fcd_pkg::DATA_RST;
      DP_SRC2_DATA <= fcd_pkg::DATA_RST;
      DP_HOST_DATA <= '0;
      DP_ACC_DATA  <= fcd_pkg::ACC_RST;
    end
    else if (take)
    begin
      RD_DATA <= rd_nxt;
      if (is_dp)
      begin
        DP_OP        <= dec_op;
        DP_WIDE      <= INSTR[fcd_pkg::F_OP2];
        DP_INT       <= dec_int;
        DP_DEST      <= dest_creg;
        DP_SRC1      <= first_src_creg;
        DP_SRC2      <= second_src_creg;
        DP_IMM       <= imm_nxt;
        DP_SRC1_DATA <= creg_r[first_src_creg];
        DP_SRC2_DATA <= creg_r[second_src_creg];
        DP_HOST_DATA <= WDATA[31:0];
        DP_ACC_DATA  <= acc_rd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence take_op(fcd_pkg::fcd_op_t o);
    CE && INSTR_VALID && dec_op == o;
  endsequence

  sequence read_answer;
    RD_VALID && ACCEPT;
  endsequence

  ld32_sext_a: assert property (
    take_op(fcd_pkg::OP_LD_32) |=>
      creg_r[$past(dest_creg)] ==
        {{32{$past(WDATA[31])}}, $past(WDATA[31:0])})
    else $error("32-bit load not sign extended");

  single_move_a: assert property (
    take_op(fcd_pkg::OP_MV_SR) |=>
      creg_r[$past(first_src_creg)][63:32] == $past(WDATA[31:0]) &&
      creg_r[$past(first_src_creg)][31:0] ==
        $past(creg_r[first_src_creg][31:0]))
    else $error("single move placed wrongly");

  int_low_move_a: assert property (
    take_op(fcd_pkg::OP_MV_64LR) |=>
      creg_r[$past(first_src_creg)][63:31] == {33{$past(WDATA[31])}})
    else $error("integer low move not sign extended");

  low_read_a: assert property (
    take_op(fcd_pkg::OP_MV_R64L) |=> read_answer ##0
      RD_DATA[31:0] == $past(creg_r[first_src_creg][31:0]))
    else $error("low read returned wrong half");

  high_read_a: assert property (
    take_op(fcd_pkg::OP_MV_RS) |=> read_answer ##0
      RD_DATA[31:0] == $past(creg_r[first_src_creg][63:32]))
    else $error("single read returned wrong half");

  store64_a: assert property (
    take_op(fcd_pkg::OP_ST_64) |=> read_answer ##0
      RD_DATA == $past(creg_r[dest_creg]))
    else $error("64-bit store data wrong");

  undef_quiet_a: assert property (
    take_op(fcd_pkg::OP_NONE) |=> !ACCEPT && !RD_VALID && !DP_VALID)
    else $error("undefined instruction answered");

  add_decode_a: assert property (
    take && INSTR[27:24] == fcd_pkg::CLASS_CO && !INSTR[4] &&
    INSTR[21:20] == 2'b11 && INSTR[11:8] == fcd_pkg::CP_FLOAT &&
    INSTR[7:5] == 3'h4 |=>
      DP_VALID && DP_OP == fcd_pkg::OP_ADD && !DP_INT && !DP_WIDE)
    else $error("single add decoded wrongly");

  width_bit_a: assert property (
    take && INSTR[27:25] == fcd_pkg::CLASS_LS &&
    INSTR[11:8] == fcd_pkg::CP_INT && INSTR[22] && INSTR[20] |->
      dec_op == fcd_pkg::OP_LD_64)
    else $error("64-bit integer load decoded wrongly");

  freeze_a: assert property (
    !CE |=> $stable(ACCEPT) && $stable(RD_DATA) && $stable(DP_VALID))
    else $error("state moved while clock enable low");

endmodule : fcd_top

`default_nettype wire

/* verification/fcd_host_model.sv */
// Host core model that issues coprocessor instructions
`default_nettype none

module fcd_host_model
(
  input  wire logic  clk,
  output logic       instr_valid,
  output logic [31:0] instr,
  output logic [63:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    instr_valid = 1'b0;
    instr       = 32'h0;
    wdata       = 64'h0;
  end

  // Drive at a falling edge, hold across one take edge
  task automatic issue(input logic [31:0] i, input logic [63:0] w);
    instr_valid = 1'b1;
    instr       = {4'hE, i[27:0]};
    wdata       = w;
    @(negedge clk);
  endtask : issue

  // Released lines show the inverse of the last value
  task automatic idle();
    instr_valid = 1'b0;
    instr       = ~instr;
    wdata       = ~wdata;
  endtask : idle
endmodule : fcd_host_model

`default_nettype wire

/* verification/fcd_top_tb_top.sv */
// Self-checking bench of the coprocessor decode front end
`default_nettype none

module fcd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic             clk, rst, ce, iv, acc, rdv, dpv, dpw, dpi;
  logic [31:0]      ins, hd, v;
  logic [63:0]      wd, rdd, sd1, sd2, w;
  logic [6:0]       imm;
  logic [71:0]      ad;
  fcd_pkg::fcd_op_t dop;
  logic [63:0]      reg_m [16];
  logic [71:0]      acc_m [4] = '{default: 72'h0};
  logic [31:0]      und [4];
  logic [31:0]      seed = 32'hBF296066;
  logic [3:0]       c, b, x, dd, ds1, ds2;
  logic [2:0]       s;
  logic [1:0]       q;
  int               n_errors = 0;
  int               tests_run = 0;

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  fcd_host_model h (.clk(clk), .instr_valid(iv), .instr(ins), .wdata(wd));

  fcd_top dut
  (
    .CLK(clk), .RST(rst), .CE(ce), .INSTR_VALID(iv), .INSTR(ins),
    .WDATA(wd), .ACCEPT(acc), .RD_VALID(rdv), .RD_DATA(rdd),
    .DP_VALID(dpv), .DP_OP(dop), .DP_WIDE(dpw), .DP_INT(dpi),
    .DP_DEST(dd), .DP_SRC1(ds1), .DP_SRC2(ds2), .DP_IMM(imm),
    .DP_SRC1_DATA(sd1), .DP_SRC2_DATA(sd2), .DP_HOST_DATA(hd),
    .DP_ACC_DATA(ad)
  );

  task automatic chk(string nm, logic [71:0] sn, logic [71:0] ex);
    tests_run++;
    if (sn !== ex)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk

  task automatic end_sim();
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] ls(logic n, logic l, logic [3:0] k,
                                     logic [3:0] d);
    logic [31:0] r;
    r = rnd();
    return {4'hE, 3'h6, r[2:1], n, r[0], l, r[19:16], d, k, r[7:0]};
  endfunction : ls

  function automatic logic [31:0] xf(logic t, logic [3:0] n, logic [3:0] k,
                                     logic [2:0] o, logic [3:0] m);
    return {8'hEE, 3'h0, t, n, seed[15:12], k, o, 1'b1, m};
  endfunction : xf

  function automatic logic [31:0] cd(logic [1:0] p, logic [3:0] n,
                                     logic [3:0] d, logic [3:0] k,
                                     logic [2:0] o, logic [3:0] m);
    return {8'hEE, seed[1:0], p, n, d, k, o, 1'b0, m};
  endfunction : cd

  initial
  begin
    repeat (3000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  initial
  begin
    rst = 1'b1;
    ce  = 1'b1;
    repeat (16) @(negedge clk);
    chk("reset", {acc, rdv, dpv, rdd}, 72'h0);
    rst = 1'b0;
    for (int r = 0; r < 16; r++)
    begin
      w = {rnd(), rnd()};
      h.issue(ls(1, 1, 4'h5, 4'(r)), w);
      reg_m[r] = w;
      chk("load_accept", 72'(acc), 72'h1);
      q = 2'(r);
      w = {rnd(), rnd()};
      h.issue(ls(q[1], 1, {3'h2, q[0]}, 4'(r)), w);
      case (q)
        0: reg_m[r][63:32] = w[31:0];
        1: reg_m[r] = {{32{w[31]}}, w[31:0]};
        default: reg_m[r] = w;
      endcase
      q = q + 2'h1;
      h.issue(ls(q[1], 0, {3'h2, q[0]}, 4'(r)), ~w);
      w = q == 0 ? {32'h0, reg_m[r][63:32]} :
          q == 1 ? {32'h0, reg_m[r][31:0]} : reg_m[r];
      chk("store", {7'h0, rdv, rdd}, {8'h1, w});
    end
    for (int r = 0; r < 16; r++)
    begin
      c = {3'h2, r[0]};
      for (int o = 0; o < 3 - r[0]; o++)
      begin
        w = {32'h0, rnd()};
        h.issue(xf(0, 4'(r), c, 3'(o), 4'h0), w);
        if (o == 0)
          reg_m[r] = r[0] ? {{32{w[31]}}, w[31:0]}
                          : {reg_m[r][63:32], w[31:0]};
        else
          reg_m[r][63:32] = w[31:0];
        chk("move_in", 72'(acc), 72'h1);
      end
      for (int o = 0; o < 3 - r[0]; o++)
      begin
        h.issue(xf(1, 4'(r), c, 3'(o), 4'h0), w);
        chk("move_out", {7'h0, rdv, rdd}, {8'h1, 32'h0, o ?
            reg_m[r][63:32] : reg_m[r][31:0]});
      end
    end
    for (int i = 0; i < 20; i++)
    begin
      b = 4'(i);
      x = 4'(i / 5);
      s = (i % 5 == 0) ? 3'h6 : 3'(i % 5 + 1);
      h.issue(cd(2'h2, b, x, 4'h4, s, b), w);
      case (s)
        2: acc_m[x[1:0]][31:0] = reg_m[b][31:0];
        3: acc_m[x[1:0]][63:32] = reg_m[b][31:0];
        4: acc_m[x[1:0]][71:64] = reg_m[b][7:0];
        5: acc_m[x[1:0]] = {{40{reg_m[b][31]}}, reg_m[b][31:0]};
        default: acc_m[x[1:0]] = {{8{reg_m[b][63]}}, reg_m[b]};
      endcase
      h.issue(cd(2'h3, x, b, 4'h4, 3'h4, b), w);
      chk("accum", ad, acc_m[x[1:0]]);
      chk("source", {sd1, sd2[7:0]}, {reg_m[x], reg_m[b][7:0]});
    end
    for (int i = 0; i < 22; i++)
    begin
      v = rnd();
      w = {rnd(), rnd()};
      s = i < 16 ? 3'(i) : i < 20 ? 3'(4 + i % 2) : 3'(i - 18);
      c = {3'h2, i < 16 ? i[3] : i > 17};
      if (i < 16)
        h.issue(cd(2'h3, v[3:0], v[7:4], c, s, v[11:8]), w);
      else
        h.issue(xf(i < 20, v[3:0], c, s, v[11:8]), w);
      x = i > 19 ? {3'h0, s[0]} + 4'h6 : i > 15 ? 4'h5 : {2'h0, s[2:1]} + 4'h1;
      chk("op", 72'(dop), 72'(x == 1 ? fcd_pkg::OP_ABS : x == 2 ?
          fcd_pkg::OP_NEG : x == 3 ? fcd_pkg::OP_ADD : x == 4 ?
          fcd_pkg::OP_SUB : x == 5 ? fcd_pkg::OP_CMP : x == 6 ?
          fcd_pkg::OP_RSHL32 : fcd_pkg::OP_RSHL64));
      chk("fields", {dpv, dpw, dpi, imm}, {1'b1, s[0], c[0], s, v[11:8]}
          );
      chk("regs", {dd, ds1, ds2},
          {i < 16 ? v[7:4] : seed[15:12], v[3:0], v[11:8]});
      if (i > 19)
        chk("host_data", 72'(hd), 72'(w[31:0]));
    end
    und = '{ls(1, 1, 4'h7, 4'h0), ls(0, 1, 4'h6, 4'h0),
           xf(1, 4'h0, 4'h4, 3'h3, 4'h0), cd(2'h0, 0, 0, 4'h6, 3'h0, 0)};
    for (int i = 0; i < 4; i++)
    begin
      h.issue(und[i], {rnd(), rnd()});
      chk("undefined", {acc, rdv, dpv}, 72'h0);
    end
    h.issue(ls(1, 0, 4'h5, 4'h0), w);
    chk("kept", 72'(rdd), 72'(reg_m[0]));
    ce = 1'b0;
    h.issue(ls(1, 1, 4'h5, 4'h0), ~reg_m[0]);
    chk("freeze", {acc, rdv, rdd}, {2'h3, reg_m[0]});
    ce = 1'b1;
    h.issue(ls(1, 0, 4'h5, 4'h0), w);
    chk("frozen_load", 72'(rdd), 72'(reg_m[0]));
    h.idle();
    @(negedge clk);
    chk("idle", {acc, rdv, dpv}, 72'h0);
    end_sim();
  end
endmodule : fcd_top_tb_top

`default_nettype wire
